//--- dv/rss_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rss_assertions
   import rss_pkg::*;
(
   input wire logic                       clk,
   input wire logic                       rst_n,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [7:0]                 paddr,
   input wire logic [31:0]                pwdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       rxActive,
   input wire logic [rss_pkg::GAIN_W-1:0] ifGainSetting,
   input wire logic                       polyphaseEnable,
   input wire logic                       irqPinA,
   input wire logic                       irqPinB,
   input wire logic                       irqLine
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Write strobe and data fields
   wire logic       wr    = psel && penable && pready && pwrite;
   wire logic [2:0] wMode = pwdata[2:0];
   wire logic [1:0] wLow  = pwdata[1:0];
   sequence setupPh; psel && !penable; endsequence
   sequence accessPh; psel && penable; endsequence
   chk_pready_wait: assert property (setupPh ##1 accessPh
      |-> !pready ##1 pready)
      else $error("pready not on second access cycle");
   chk_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_bad_addr: assert property (pready
      && (paddr > ADDR_ENABLE || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("bad address not refused");
   chk_mode_rx: assert property (wr && paddr == ADDR_MODE
      |-> ##2 rxActive == ($past(wMode, 2) == MODE_RX))
      else $error("receive state wrong after mode write");
   chk_gain_write: assert property (wr && paddr == ADDR_GAIN
      |-> ##2 ifGainSetting == $past(wLow, 2))
      else $error("gain output wrong after write");
   chk_poly_write: assert property (wr && paddr == ADDR_FILT
      |-> ##2 polyphaseEnable == $past(wMode[0], 2))
      else $error("polyphase enable wrong after write");
   chk_route_off: assert property (wr && paddr == ADDR_ROUTE
      && wLow == 2'h0 |-> ##2 !irqPinA && !irqPinB)
      else $error("unrouted pin still high");
   chk_line_mask: assert property (wr && paddr == ADDR_ENABLE
      && !pwdata[0] |-> ##2 !irqLine)
      else $error("masked interrupt line high");
   chk_irq_hold: assert property (irqPinA && !wr && !$past(wr)
      |=> irqPinA)
      else $error("pin dropped without clear");
endmodule
`default_nettype wire

//--- dv/rss_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rss_host_model
   import rss_pkg::*;
#(
   // Filter codes: plain defaults, real encodings unknown here
   parameter logic [CEN_W-1:0]  CEN_100K = 3'h0,
   parameter logic [CUT_W-1:0]  CUT_SEL  = 4'h2,
   parameter logic [PASS_W-1:0] PASS_SEL = 4'h8
)
(
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = BUS_ZERO;
   end
   // ==========================================
   // One transfer; only the bench timeout ends a hang
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      @(posedge clk);
   endtask
   // Deviation kept equal to the second IF
   task automatic cfg(input logic fsk, input logic [7:0] dev);
      logic [31:0] f;
      logic [31:0] q;
      f = BUS_ZERO;
      f[POLY_BIT] = !fsk;
      f[CUT_LSB+:CUT_W] = CUT_SEL;
      f[CEN_LSB+:CEN_W] = CEN_100K;
      f[PASS_LSB+:PASS_W] = PASS_SEL;
      f[FSK_BIT] = fsk;
      xfer(1'b1, ADDR_DEV, {24'h00_0000, dev}, q);
      xfer(1'b1, ADDR_FILT, f, q);
   endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import rss_pkg::*;
   logic              clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr, iqMagnitude, v;
   logic [31:0]       pwdata, prdata, q;
   logic              demodBit, bitClkEn, continuousMode, rxActive;
   logic              polyphaseEnable, syncClk, fifoBitValid;
   logic              irqPinA, irqPinB, irqLine;
   logic [GAIN_W-1:0] ifGainSetting;
   logic [CUT_W-1:0]  cutSet;
   logic [CEN_W-1:0]  cenSet;
   logic [PASS_W-1:0] passSet;
   logic              syncData, fifoBit, cmD, dbD;
   logic [33:0]       expQ[$];
   int                n_errors, tests_run, cyc, sc[2], fv[2];
   localparam logic [7:0] RA[8] = '{ADDR_MODE, ADDR_GAIN, ADDR_FILT,
      ADDR_DEV, ADDR_LEVEL, ADDR_ROUTE, ADDR_STATUS, ADDR_ENABLE};
   localparam logic [31:0] RV[8] = '{MODE_RST, GAIN_RST, FILT_RST,
      DEV_RST, LEVEL_RST, BUS_ZERO, BUS_ZERO, BUS_ZERO};
   rss_top dut_u(.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .iqMagnitude, .demodBit, .bitClkEn,
      .continuousMode, .rxActive, .ifGainSetting, .polyphaseEnable,
      .channelCutoffSetting(cutSet), .polyphaseCenterSetting(cenSet),
      .passiveFilterBw(passSet), .syncClk, .syncData, .fifoBit,
      .fifoBitValid, .irqPinA, .irqPinB, .irqLine);
   rss_host_model host_u(.clk, .pready, .prdata, .psel, .penable,
      .pwrite, .paddr, .pwdata);
   always #20 clk = ~clk;
   // ==========================================
   // Checking and closing
   task automatic chk(input string nm, input logic [32:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task finish_test;
      $display("Checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic er = 0);
      expQ.push_back({1'b1, er, e});
      host_u.xfer(1'b0, a, BUS_ZERO, q);
   endtask
   // Read completions matched oldest-first; also random bit stream
   always @(posedge clk) begin : mon
      logic [33:0] e;
      if ((psel & penable & pready & ~pwrite) === 1'b1
          && expQ.size() > 0) begin
         e = expQ.pop_front();
         if (e[33]) chk("read", {pslverr, prdata}, e[32:0]);
      end
      // Strobes lag the mode and data inputs by one edge
      if (syncClk === 1'b1) begin
         sc[cmD]++;
         chk("syncData", syncData, dbD);
      end
      if (fifoBitValid === 1'b1) begin
         fv[cmD]++;
         chk("fifoBit", fifoBit, dbD);
      end
      cmD <= continuousMode;
      dbD <= demodBit;
      bitClkEn <= ($urandom % 4) == 0;
      demodBit <= 1'($urandom);
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         finish_test;
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      iqMagnitude = 8'h00;
      continuousMode = 1'b0;
      void'($urandom(32'h34fe));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (RA[i]) rd(RA[i], RV[i]);
      rd(8'h28, BUS_ZERO, 1'b1);
      rd(8'h02, BUS_ZERO, 1'b1);
      wr(ADDR_STATUS, 32'h0000_0001);
      rd(ADDR_STATUS, BUS_ZERO);
      for (int g = 0; g < 4; g++) begin
         wr(ADDR_GAIN, g);
         rd(ADDR_GAIN, g);
         chk("gain", ifGainSetting, g);
      end
      for (int m = 0; m < 8; m++) begin
         wr(ADDR_MODE, m);
         repeat (2) @(posedge clk);
         chk("rx", rxActive, m == 3);
      end
      for (int k = 0; k < 2; k++) begin
         iqMagnitude <= 8'h00;
         repeat (250) @(posedge clk);
         host_u.cfg(k[0], 8'h05);
         @(posedge clk);
         chk("poly", polyphaseEnable, !k[0]);
         chk("filt", {cutSet, cenSet, passSet},
             {host_u.CUT_SEL, host_u.CEN_100K, host_u.PASS_SEL});
         wr(ADDR_MODE, MODE_RX);
         v = 8'($urandom_range(255, 64));
         iqMagnitude <= v;
         repeat (40) @(posedge clk);
         // Ramp value only bounded, so the read note skips compare
         expQ.push_back(34'h0_0000_0000);
         host_u.xfer(1'b0, ADDR_STRENGTH, BUS_ZERO, q);
         // At most four samples by now at one per 12 clocks
         chk("ramp", q[7:0] <= v / 4, 1'b1);
         repeat (250) @(posedge clk);
         rd(ADDR_STRENGTH, v);
      end
      continuousMode <= 1'b1;
      wr(ADDR_LEVEL, v);
      wr(ADDR_ROUTE, 32'h0000_0001);
      wr(ADDR_ENABLE, 32'h0000_0001);
      rd(ADDR_STATUS, BUS_ZERO);
      wr(ADDR_LEVEL, v - 1);
      repeat (4) @(posedge clk);
      rd(ADDR_STATUS, 32'h0000_0001);
      chk("pins", {irqPinA, irqPinB, irqLine}, 3'b101);
      wr(ADDR_ROUTE, 32'h0000_0002);
      wr(ADDR_CLEAR, BUS_ZERO);
      wr(ADDR_CLEAR, 32'h0000_0001);
      rd(ADDR_STATUS, 32'h0000_0001);
      chk("pins", {irqPinA, irqPinB, irqLine}, 3'b011);
      wr(ADDR_ENABLE, BUS_ZERO);
      wr(ADDR_ROUTE, BUS_ZERO);
      wr(ADDR_LEVEL, 32'h0000_00ff);
      wr(ADDR_CLEAR, 32'h0000_0001);
      repeat (3) @(posedge clk);
      rd(ADDR_STATUS, BUS_ZERO);
      chk("pins", {irqPinA, irqPinB, irqLine}, 3'b000);
      chk("sync", sc[0] + fv[1] == 0 && sc[1] > 0 && fv[0] > 0, 1);
      finish_test;
   end
endmodule
bind rss_top rss_assertions chk_u(.clk, .rst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .rxActive, .ifGainSetting,
   .polyphaseEnable, .irqPinA, .irqPinB, .irqLine);
`default_nettype wire

//--- logic/rss_pkg.sv
package rss_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_MODE    = 8'h00;
   localparam logic [7:0] ADDR_GAIN    = 8'h04;
   localparam logic [7:0] ADDR_FILT    = 8'h08;
   localparam logic [7:0] ADDR_DEV     = 8'h0C;
   localparam logic [7:0] ADDR_LEVEL   = 8'h10;
   localparam logic [7:0] ADDR_ROUTE   = 8'h14;
   localparam logic [7:0] ADDR_STRENGTH = 8'h18;
   localparam logic [7:0] ADDR_STATUS  = 8'h1C;
   localparam logic [7:0] ADDR_CLEAR   = 8'h20;
   localparam logic [7:0] ADDR_ENABLE  = 8'h24;
   // ==========================================
   // Fields
   localparam int MODE_W     = 3;
   localparam int GAIN_W     = 2;
   localparam int DEV_W      = 8;
   localparam int STR_W      = 8;
   localparam int SAMP_W     = 8;
   localparam int WIN_N      = 16;
   localparam int SUM_W      = 12;
   localparam int POLY_BIT   = 0;
   localparam int CUT_LSB    = 1;
   localparam int CUT_W      = 4;
   localparam int CEN_LSB    = 5;
   localparam int CEN_W      = 3;
   localparam int PASS_LSB   = 8;
   localparam int PASS_W     = 4;
   localparam int FSK_BIT    = 12;
   localparam int FILT_W     = 13;
   localparam int ALARM_BIT  = 0;
   // ==========================================
   // Reset values and codes
   localparam logic [MODE_W-1:0] MODE_RX     = 3'h3;
   localparam logic [MODE_W-1:0] MODE_RST    = 3'h0;
   localparam logic [GAIN_W-1:0] GAIN_RST    = 2'h0;
   localparam logic [DEV_W-1:0]  DEV_RST     = 8'h03;
   localparam logic [STR_W-1:0]  LEVEL_RST   = 8'hFF;
   localparam logic [FILT_W-1:0] FILT_RST    = 13'h0000;
   localparam logic [31:0]       BUS_ZERO    = 32'h0000_0000;
   // Sample rate: 16 per period of F = Fxtal/(32*(1+dev))
   // so one sample per 2*(1+dev) reference ticks
   localparam int TICK_MUL   = 2;
   localparam int CNT_W      = 10;
endpackage

//--- logic/rss_sample_timer.sv
`timescale 1ns/100ps
`default_nettype none
module rss_sample_timer
   import rss_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               run,
   input  wire logic [DEV_W-1:0]   devSetting,
   output logic                    sampleTick
);
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] limit;

   // 16 samples per deviation / second-IF period
   assign limit = CNT_W'((32'(devSetting) + 32'd1) * TICK_MUL - 1);

   always_ff @(posedge clk) begin
      if (!rst_n || !run || count_r >= limit) begin
         count_r <= '0;
      end else begin
         count_r <= count_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sampleTick <= 1'b0;
      end else begin
         sampleTick <= run && (count_r >= limit);
      end
   end
endmodule
`default_nettype wire

//--- logic/rss_top.sv
// How it works
// - Receive operation runs only while the mode field holds 011.
// - IF gain code 0..3 gives 0, -4.5, -9, -13.5 dB; reset is 0 dB.
// - One step of the strength value is 0.5 dB.
// - In OOK the I/Q magnitude is sampled 16 times per second-IF period.
// - In FSK the I/Q magnitude is sampled 16 times per deviation period.
// - The strength is the mean of the latest sixteen samples.
// - The readable strength refreshes once per new sample.
// - The alarm flag sets when strength exceeds the alarm level while receive is on (mode 011).
// - The alarm flag stays set until software writes one to clear it.
// - Two route bits steer the alarm to interrupt pin a or pin b.
// - One bit picks low-pass or polyphase channel filtering.
// - Resynchroniser feeds the host in continuous mode, FIFO otherwise.
`timescale 1ns/100ps
`default_nettype none
module rss_top
   import rss_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Baseband magnitude sample, 0.5 dB per step
   input  wire logic [SAMP_W-1:0]    iqMagnitude,
   // Demodulated data and resynchroniser controls
   input  wire logic                 demodBit,
   input  wire logic                 bitClkEn,
   input  wire logic                 continuousMode,
   // Analogue controls
   output logic                      rxActive,
   output logic [GAIN_W-1:0]         ifGainSetting,
   output logic                      polyphaseEnable,
   output logic [CUT_W-1:0]          channelCutoffSetting,
   output logic [CEN_W-1:0]          polyphaseCenterSetting,
   output logic [PASS_W-1:0]         passiveFilterBw,
   // Resynchronised data
   output logic                      syncClk,
   output logic                      syncData,
   output logic                      fifoBit,
   output logic                      fifoBitValid,
   // Interrupt pins
   output logic                      irqPinA,
   output logic                      irqPinB,
   output logic                      irqLine
);
   // ==========================================
   // Registers
   logic [MODE_W-1:0] mode_r;
   logic [GAIN_W-1:0] gain_r;
   logic [FILT_W-1:0] filt_r;
   logic [DEV_W-1:0]  dev_r;
   logic [STR_W-1:0]  level_r;
   logic [1:0]        route_r;
   logic              alarm_r;
   logic              alarmEn_r;
   logic              rxOn;
   logic              sampleTick;
   logic [STR_W-1:0]  mean;
   logic              meanValid;
   logic [STR_W-1:0]  strength_r;
   logic              wrAcc;
   logic              rdAcc;
   logic              known;
   logic              alarmSet;

   assign rxOn  = (mode_r == MODE_RX);
   assign wrAcc = psel && penable && pwrite && pready;
   assign rdAcc = psel && !penable && !pwrite;
   assign known = (paddr <= ADDR_ENABLE) && (paddr[1:0] == 2'b00);

   // ==========================================
   // APB: one wait state, answer in second access cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && penable && !pready && !known;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_r  <= MODE_RST;
         gain_r  <= GAIN_RST;
         filt_r  <= FILT_RST;
         dev_r   <= DEV_RST;
         level_r <= LEVEL_RST;
         route_r <= 2'b00;
         alarmEn_r <= 1'b0;
      end else if (wrAcc) begin
         case (paddr)
            ADDR_MODE:   mode_r  <= pwdata[MODE_W-1:0];
            ADDR_GAIN:   gain_r  <= pwdata[GAIN_W-1:0];
            ADDR_FILT:   filt_r  <= pwdata[FILT_W-1:0];
            ADDR_DEV:    dev_r   <= pwdata[DEV_W-1:0];
            ADDR_LEVEL:  level_r <= pwdata[STR_W-1:0];
            ADDR_ROUTE:  route_r <= pwdata[1:0];
            ADDR_ENABLE: alarmEn_r <= pwdata[ALARM_BIT];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= BUS_ZERO;
      end else if (rdAcc) begin
         case (paddr)
            ADDR_MODE:     prdata <= 32'(mode_r);
            ADDR_GAIN:     prdata <= 32'(gain_r);
            ADDR_FILT:     prdata <= 32'(filt_r);
            ADDR_DEV:      prdata <= 32'(dev_r);
            ADDR_LEVEL:    prdata <= 32'(level_r);
            ADDR_ROUTE:    prdata <= 32'(route_r);
            ADDR_STRENGTH: prdata <= 32'(strength_r);
            ADDR_STATUS:   prdata <= 32'(alarm_r);
            ADDR_ENABLE:   prdata <= 32'(alarmEn_r);
            default:       prdata <= BUS_ZERO;
         endcase
      end
   end

   // ==========================================
   // Strength estimator
   // Same divider serves OOK (dev = IF2) and FSK (dev = Fdev)
   rss_sample_timer u_timer (
      .clk        (clk),
      .rst_n      (rst_n),
      .run        (rxOn),
      .devSetting (dev_r),
      .sampleTick (sampleTick)
   );

   rss_window_avg u_avg (
      .clk       (clk),
      .rst_n     (rst_n),
      .sampleEn  (sampleTick),
      .sampleIn  (iqMagnitude),
      .meanOut   (mean),
      .meanValid (meanValid)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strength_r <= '0;
      end else if (meanValid) begin
         strength_r <= mean;
      end
   end

   // ==========================================
   // Alarm flag: set beats a simultaneous clear
   assign alarmSet = rxOn && (strength_r > level_r);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alarm_r <= 1'b0;
      end else if (alarmSet) begin
         alarm_r <= 1'b1;
      end else if (wrAcc && paddr == ADDR_CLEAR && pwdata[ALARM_BIT]) begin
         alarm_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irqPinA <= 1'b0;
         irqPinB <= 1'b0;
         irqLine <= 1'b0;
      end else begin
         irqPinA <= alarm_r && route_r[0];
         irqPinB <= alarm_r && route_r[1];
         irqLine <= alarm_r && alarmEn_r;
      end
   end

   // ==========================================
   // Analogue control outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxActive               <= 1'b0;
         ifGainSetting          <= GAIN_RST;
         polyphaseEnable        <= 1'b0;
         channelCutoffSetting   <= '0;
         polyphaseCenterSetting <= '0;
         passiveFilterBw        <= '0;
      end else begin
         rxActive               <= rxOn;
         ifGainSetting          <= gain_r;
         polyphaseEnable        <= filt_r[POLY_BIT];
         channelCutoffSetting   <= filt_r[CUT_LSB +: CUT_W];
         polyphaseCenterSetting <= filt_r[CEN_LSB +: CEN_W];
         passiveFilterBw        <= filt_r[PASS_LSB +: PASS_W];
      end
   end

   // ==========================================
   // Bit resynchroniser: data captured on recovered bit strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         syncClk      <= 1'b0;
         syncData     <= 1'b0;
         fifoBit      <= 1'b0;
         fifoBitValid <= 1'b0;
      end else begin
         syncClk      <= rxOn && continuousMode && bitClkEn;
         fifoBitValid <= rxOn && !continuousMode && bitClkEn;
         if (rxOn && bitClkEn) begin
            syncData <= demodBit;
            fifoBit  <= demodBit;
         end
      end
   end
endmodule
`default_nettype wire

//--- logic/rss_window_avg.sv
`timescale 1ns/100ps
`default_nettype none
module rss_window_avg
   import rss_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              sampleEn,
   input  wire logic [SAMP_W-1:0] sampleIn,
   output logic [STR_W-1:0]       meanOut,
   output logic                   meanValid
);
   logic [SAMP_W-1:0] hist_r [WIN_N];
   logic [3:0]        idx_r;
   logic [SUM_W-1:0]  sum_r;
   logic [SUM_W-1:0]  sumNxt;

   // Running sum: add newest, drop the one it overwrites
   assign sumNxt = sum_r + SUM_W'(sampleIn) - SUM_W'(hist_r[idx_r]);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < WIN_N; i++) begin
            hist_r[i] <= '0;
         end
         idx_r <= '0;
         sum_r <= '0;
      end else if (sampleEn) begin
         hist_r[idx_r] <= sampleIn;
         idx_r         <= idx_r + 1'b1;
         sum_r         <= sumNxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meanOut   <= '0;
         meanValid <= 1'b0;
      end else begin
         meanValid <= sampleEn;
         if (sampleEn) begin
            meanOut <= sumNxt[SUM_W-1:4];
         end
      end
   end
endmodule
`default_nettype wire
